/* File: ustc_pkg.sv */
// package: register map, fields and timing for the serial transmit control
`default_nettype none
package ustc_pkg;
  // register byte addresses
  localparam logic [7:0] TXSC_ADDR = 8'h98;
  localparam logic [7:0] RXSC_ADDR = 8'h9c;
  localparam logic [7:0] DIR_ADDR  = 8'ha0;
  localparam logic [7:0] BUF_ADDR  = 8'ha4;
  localparam logic [7:0] BAUD_ADDR = 8'ha8;
  // transmit_status_control fields; F_SERIAL_PORT_ENABLE sits in the receive control register
  localparam int F_CLOCK_SOURCE_SELECT = 7;
  localparam int F_TX9  = 6;
  localparam int F_TRANSMIT_ENABLE = 5;
  localparam int F_SYNC = 4;
  localparam int F_HIGH_BAUD_SELECT = 2;
  localparam int F_SHIFT_REGISTER_EMPTY = 1;
  localparam int F_NINTH_TRANSMIT_BIT = 0;
  localparam int F_SERIAL_PORT_ENABLE = 7;
  localparam logic [7:0] TXSC_RESET = 8'h02;
  localparam logic [7:0] TXSC_WMASK = 8'hf5;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // reload values of the per-bit tick counter, one less than the baud ticks per bit
  localparam logic [5:0] RATIO_HIGH = 6'h0f;
  localparam logic [5:0] RATIO_LOW  = 6'h3f;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FIFO_DEPTH = 4;
  // nine-bit character carried through the buffer
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ustc_char_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } ustc_state_t;
endpackage : ustc_pkg
`default_nettype wire

/* File: ustc_fifo.sv */
// fifo: small flip-flop buffer with valid/ready on both sides
`default_nettype none
module ustc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr, rptr, next_wptr, next_rptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;
  // handshake terms
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // pointer and count update
  always_comb begin
    next_wptr  = push ? wptr + 1'b1 : wptr;
    next_rptr  = pop ? rptr + 1'b1 : rptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_wptr  = '0;
      next_rptr  = '0;
      next_count = '0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end
  // storage written by index
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
endmodule : ustc_fifo
`default_nettype wire

/* File: ustc_top.sv */
// top: register slave, pin enables and transmitter of the serial unit
// Function
// - asynchronous mode gives a full-duplex start/stop link with hosts.
// - synchronous mode shifts as master or slave with the transmit pin left undriven.
// - the pins serve the unit only with port enable and both directions set.
// - a ninth data bit marks address words for multi-processor use.
// - in asynchronous mode the baud tick is sixteen or sixty-four times the bit rate by speed bit.
// - shift-register-empty is read only and set while the shifter is empty.
// - clearing transmit enable aborts sending and floats the transmit pin.
`default_nettype none
module ustc_top #(
  parameter int FIFO_WORDS = ustc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // transmit/clock pin
  input  wire logic        transmit_clock_pin_i,
  output logic             transmit_clock_pin_o,
  output logic             transmit_clock_pin_oe,
  // receive/data pin (receive path lives elsewhere)
  output logic             receive_data_pin_select
);
  import ustc_pkg::*;
  logic [7:0] txsc, next_txsc;
  logic [7:0] rxsc, next_rxsc;
  logic [7:0] dirc, next_dirc;
  logic [7:0] baud, next_baud;
  logic aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0] aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic w_q_strb0, next_w_q_strb0;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic do_wr, buf_push;
  logic pins_on, transmit_enable, is_sync, master, shift_empty;
  logic f_ready, f_valid, f_pop;
  ustc_char_t f_data;
  ustc_state_t st, next_st;
  logic [7:0] brg_cnt, next_brg_cnt;
  logic [5:0] tick_cnt, next_tick_cnt;
  logic [8:0] shreg, next_shreg;
  logic [3:0] bitn, next_bitn;
  logic txo, next_txo, brg_tick, bit_en;
  logic ck_s1, ck_s2, ck_s3;
  // control decode
  assign transmit_enable    = txsc[F_TRANSMIT_ENABLE];
  assign is_sync = txsc[F_SYNC];
  assign master  = is_sync && txsc[F_CLOCK_SOURCE_SELECT];
  assign pins_on = rxsc[F_SERIAL_PORT_ENABLE] && dirc[7] && dirc[6];
  assign shift_empty = (st == ST_IDLE);
  assign receive_data_pin_select = pins_on;
  // write channel capture, address and data in either order
  assign s_axi_awready = !aw_hold && !bvalid;
  assign s_axi_wready  = !w_hold && !bvalid;
  assign do_wr   = aw_hold && w_hold && !bvalid;
  assign buf_push = do_wr && aw_q == BUF_ADDR && w_q_strb0;
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_q    = aw_q;
    next_w_q     = w_q;
    next_w_q_strb0 = w_q_strb0;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_txsc    = txsc;
    next_rxsc    = rxsc;
    next_dirc    = dirc;
    next_baud    = baud;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_q    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold    = 1'b1;
      next_w_q       = s_axi_wdata;
      next_w_q_strb0 = s_axi_wstrb[0];
    end
    if (do_wr) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_q)
        TXSC_ADDR: if (w_q_strb0) begin
          // ninth bit stored, empty flag not writable
          next_txsc = (w_q[7:0] & TXSC_WMASK) | (txsc & ~TXSC_WMASK);
        end
        RXSC_ADDR: if (w_q_strb0) next_rxsc = w_q[7:0];
        DIR_ADDR:  if (w_q_strb0) next_dirc = w_q[7:0];
        BAUD_ADDR: if (w_q_strb0) next_baud = w_q[7:0];
        BUF_ADDR:  next_bresp = f_ready ? RESP_OKAY : RESP_SLVERR;
        default:   next_bresp = RESP_SLVERR;
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_txsc[F_SHIFT_REGISTER_EMPTY] = shift_empty;
    next_txsc[3]      = 1'b0;
  end
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;
  // read channel
  assign s_axi_arready = !rvalid;
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0;
      unique case (s_axi_araddr)
        TXSC_ADDR: next_rdata[7:0] = txsc;
        RXSC_ADDR: next_rdata[7:0] = rxsc;
        DIR_ADDR:  next_rdata[7:0] = dirc;
        BAUD_ADDR: next_rdata[7:0] = baud;
        BUF_ADDR:  next_rdata[0]   = f_ready;
        default:   next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rdata;
  assign s_axi_rresp  = rresp;
  // character buffer between register write and shifter
  ustc_fifo #(.WIDTH($bits(ustc_char_t)), .DEPTH(FIFO_WORDS)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (buf_push),
    .in_ready  (f_ready),
    // ninth bit sampled when the character is written to the buffer
    .in_data   ({txsc[F_NINTH_TRANSMIT_BIT], w_q[7:0]}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data),
    .flush     (!transmit_enable)
  );
  // external clock sync for slave mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
    end else begin
      ck_s1 <= transmit_clock_pin_i;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
    end
  end
  // baud tick and x16/x64 bit divider
  assign brg_tick = (brg_cnt == 8'h00);
  always_comb begin
    next_brg_cnt  = brg_tick ? baud : brg_cnt - 8'h01;
    next_tick_cnt = tick_cnt;
    bit_en = 1'b0;
    if (is_sync) begin
      // master uses baud tick, slave a falling external edge
      bit_en = master ? brg_tick : (ck_s3 && !ck_s2);
    end else if (brg_tick) begin
      if (tick_cnt == '0) begin
        bit_en = 1'b1;
        next_tick_cnt = txsc[F_HIGH_BAUD_SELECT] ? RATIO_HIGH : RATIO_LOW;
      end else begin
        next_tick_cnt = tick_cnt - 6'h01;
      end
    end
  end
  assign f_pop = (st == ST_IDLE) && transmit_enable && f_valid && bit_en;
  always_comb begin
    next_st    = st;
    next_shreg = shreg;
    next_bitn  = bitn;
    next_txo   = txo;
    unique case (st)
      ST_IDLE: if (f_pop) begin
        // sync puts bit 0 out at once, async the start bit first
        next_bitn = 4'h0;
        next_st   = is_sync ? ST_DATA : ST_START;
        if (is_sync) begin
          next_txo   = f_data.data[0];
          next_shreg = {1'b0, f_data.ninth, f_data.data[7:1]};
        end else begin
          next_txo   = 1'b0;
          next_shreg = {f_data.ninth, f_data.data};
        end
      end
      // start bit ends with bit 0 on the line
      ST_START: if (bit_en) begin
        next_txo   = shreg[0];
        next_shreg = {1'b0, shreg[8:1]};
        next_st    = ST_DATA;
      end
      ST_DATA: if (bit_en) begin
        if (bitn == (txsc[F_TX9] ? 4'h8 : 4'h7)) begin
          // last data bit has had its full time: idle or stop level
          next_txo = 1'b1;
          next_st  = is_sync ? ST_IDLE : ST_STOP;
        end else begin
          next_txo   = shreg[0];
          next_shreg = {1'b0, shreg[8:1]};
          next_bitn  = bitn + 4'h1;
        end
      end
      ST_STOP: if (bit_en) next_st = ST_IDLE;
    endcase
    if (!transmit_enable) begin
      next_st  = ST_IDLE;
      next_txo = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txsc <= TXSC_RESET; rxsc <= 8'h00; dirc <= 8'h00; baud <= BAUD_RESET;
      aw_hold <= 1'b0; w_hold <= 1'b0; aw_q <= 8'h00; w_q <= 32'h0;
      w_q_strb0 <= 1'b0; bvalid <= 1'b0; bresp <= 2'h0;
      rvalid <= 1'b0; rdata <= 32'h0; rresp <= 2'h0;
      st <= ST_IDLE; brg_cnt <= 8'h00; tick_cnt <= 6'h00;
      shreg <= 9'h000; bitn <= 4'h0; txo <= 1'b1;
    end else begin
      txsc <= next_txsc; rxsc <= next_rxsc; dirc <= next_dirc;
      baud <= next_baud; aw_hold <= next_aw_hold; w_hold <= next_w_hold;
      aw_q <= next_aw_q; w_q <= next_w_q; w_q_strb0 <= next_w_q_strb0;
      bvalid <= next_bvalid; bresp <= next_bresp; rvalid <= next_rvalid;
      rdata <= next_rdata; rresp <= next_rresp; st <= next_st;
      brg_cnt <= next_brg_cnt; tick_cnt <= next_tick_cnt;
      shreg <= next_shreg; bitn <= next_bitn; txo <= next_txo;
    end
  end
  // pin drive only when owned and enabled
  assign transmit_clock_pin_o  = txo;
  assign transmit_clock_pin_oe = pins_on && transmit_enable && !is_sync;

  AST_EMPTY_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 txsc[F_SHIFT_REGISTER_EMPTY] == $past(st == ST_IDLE)) else $error("empty flag wrong");
  AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
    !transmit_enable |=> st == ST_IDLE && txo) else $error("abort failed");
  AST_PIN_OWN: assert property (@(posedge aclk) disable iff (!aresetn)
    transmit_clock_pin_oe |-> rxsc[F_SERIAL_PORT_ENABLE] && dirc[7] && dirc[6])
    else $error("pin driven without ownership");
  // start bit low right after an async load
  AST_START_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    f_pop && !is_sync |=> !txo && st == ST_START) else $error("no start bit");
  // fast ratio gives sixteen ticks per bit
  AST_RATIO: assert property (@(posedge aclk) disable iff (!aresetn)
    !is_sync && bit_en && txsc[F_HIGH_BAUD_SELECT] |=> tick_cnt == RATIO_HIGH)
    else $error("ratio wrong");
  AST_NINTH: assert property (@(posedge aclk) disable iff (!aresetn)
    f_pop && !is_sync |=> shreg[8] == $past(f_data.ninth))
    else $error("ninth bit lost");
  // slave sync never uses the internal tick alone
  AST_SLAVE: assert property (@(posedge aclk) disable iff (!aresetn)
    is_sync && !master && bit_en |-> ck_s3 && !ck_s2)
    else $error("slave clock wrong");
  // stop bit high at end of data
  AST_STOP_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    st == ST_STOP |-> txo) else $error("stop not high");
  AST_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
    st == ST_DATA |-> bitn <= 4'h8) else $error("bit count overrun");
endmodule : ustc_top
`default_nettype wire

/* File: ustc_term.sv */
// partner: serial terminal that decodes frames from the transmit line
`default_nettype none
module ustc_term (
  // clock and line
  input  wire logic       aclk,
  input  wire logic       line,
  // frame setup
  input  wire logic [7:0] bit_cyc,
  input  wire logic       nine,
  // decoded character and the external clock, held still
  output logic            got,
  output logic      [8:0] ch,
  output logic            ext_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    got = 1'b0;
    ch = 9'h000;
    ext_clk = 1'b0; // no slave synchronous frames, so the clock never moves
    forever begin
      @(posedge aclk);
      got <= 1'b0;
      if (line === 1'b0) begin
        repeat (bit_cyc / 2) @(posedge aclk);
        ch = 9'h000;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (bit_cyc) @(posedge aclk);
          ch[i] = line; // lowest bit first
        end
        repeat (bit_cyc) @(posedge aclk);
        got <= 1'b1;
      end
    end
  end
endmodule : ustc_term
`default_nettype wire

/* File: test_usart_transmit_control.sv */
// testbench: register access, framing, buffer and abort checks
`default_nettype none
module test_usart_transmit_control import ustc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, nine = 0, awready, wready, bvalid;
  logic arready, rvalid, pin_o, pin_oe, pin_sel, line, got, ext_clk;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, bit_cyc = 8'h10;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic [8:0] ch;
  logic [8:0] q[$];
  int errors = 0, n_tests = 0;
  // clock, idle line pulled up, received characters queued
  always #20 aclk = ~aclk;
  assign line = pin_oe ? pin_o : 1'b1;
  always @(posedge aclk) if (got) q.push_back(ch);
  ustc_top #(.FIFO_WORDS(FIFO_DEPTH)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .transmit_clock_pin_i(ext_clk), .transmit_clock_pin_o(pin_o),
    .transmit_clock_pin_oe(pin_oe), .receive_data_pin_select(pin_sel));
  ustc_term term (.aclk(aclk), .line(line), .bit_cyc(bit_cyc),
    .nine(nine), .got(got), .ch(ch), .ext_clk(ext_clk));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic tmo();
    errors++;
    $display("mismatch wait expected answer seen timeout");
    print_verdict();
  endtask : tmo
  // bus write: both channels offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 40) tmo();
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : axw
  // bus read with response and data check
  task automatic axr(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 40) tmo();
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    if (er == RESP_OKAY) chk("rdata", rdata, e);
  endtask : axr
  task automatic waitq(input int n);
    int i;
    for (i = 0; i < 4000 && q.size() < n; i++) @(posedge aclk);
    if (i == 4000) tmo();
  endtask : waitq
  // control first, then one character, then the decoded frame
  task automatic send(input logic [7:0] c, bc, input logic [8:0] e);
    bit_cyc = bc;
    nine = c[F_TX9];
    q.delete();
    axw(TXSC_ADDR, {24'h0, c}, RESP_OKAY);
    axw(BUF_ADDR, {24'h0, e[7:0]}, RESP_OKAY);
    waitq(1);
    chk("char", {23'h0, q[0]}, {23'h0, e});
    // let the stop bit finish so the shifter is idle again
    repeat (bc) @(posedge aclk);
  endtask : send
  task automatic t_regs();
    axr(TXSC_ADDR, 32'h02, RESP_OKAY);
    axr(8'hb0, 32'h0, RESP_SLVERR);
    axw(TXSC_ADDR, 32'hfa, RESP_OKAY);
    axr(TXSC_ADDR, 32'hf2, RESP_OKAY);
    axw(TXSC_ADDR, 32'h01, RESP_OKAY);
    axr(TXSC_ADDR, 32'h03, RESP_OKAY);
    $display("test regs done");
  endtask : t_regs
  task automatic t_pins();
    axw(RXSC_ADDR, 32'h80, RESP_OKAY);
    chk("pin_sel", {31'h0, pin_sel}, 32'h0);
    axw(DIR_ADDR, 32'h40, RESP_OKAY);
    chk("pin_sel", {31'h0, pin_sel}, 32'h0);
    axw(DIR_ADDR, 32'hc0, RESP_OKAY);
    chk("pin_sel", {31'h0, pin_sel}, 32'h1);
    $display("test pins done");
  endtask : t_pins
  task automatic t_sync();
    logic [7:0] sc;
    sc = 8'ha5;
    axw(TXSC_ADDR, 32'hb0, RESP_OKAY);
    axr(TXSC_ADDR, 32'hb2, RESP_OKAY);
    chk("pin_oe", {31'h0, pin_oe}, 32'h0);
    // master with divisor 0 shifts one bit per cycle, lowest first
    axw(BUF_ADDR, {24'h0, sc}, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      chk("sync_bit", {31'h0, pin_o}, {31'h0, sc[i]});
    end
    axw(TXSC_ADDR, 32'h30, RESP_OKAY);
    axr(TXSC_ADDR, 32'h32, RESP_OKAY);
    $display("test sync done");
  endtask : t_sync
  task automatic t_frames();
    send(8'h24, 8'd16, 9'h0a5);
    axr(TXSC_ADDR, 32'h26, RESP_OKAY);
    send(8'h20, 8'd64, 9'h05a);
    send(8'h65, 8'd16, 9'h13c);
    send(8'h64, 8'd16, 9'h0c3);
    $display("test frames done");
  endtask : t_frames
  task automatic t_fifo();
    q.delete();
    nine = 1'b0;
    bit_cyc = 8'd16;
    axw(TXSC_ADDR, 32'h24, RESP_OKAY);
    // first character reaches the shifter before the buffer fills
    axw(BUF_ADDR, 32'h10, RESP_OKAY);
    repeat (20) @(posedge aclk);
    for (int i = 1; i < 5; i++) axw(BUF_ADDR, 32'h10 + i, RESP_OKAY);
    axw(BUF_ADDR, 32'h77, RESP_SLVERR);
    axr(BUF_ADDR, 32'h0, RESP_OKAY);
    waitq(5);
    for (int i = 0; i < 5; i++) chk("fifo", {23'h0, q[i]}, 32'h10 + i);
    // last stop bit runs out before the next scenario
    repeat (16) @(posedge aclk);
    axr(BUF_ADDR, 32'h1, RESP_OKAY);
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_abort();
    axw(BUF_ADDR, 32'h00, RESP_OKAY);
    // give the shifter over one bit time to take the character
    repeat (20) @(posedge aclk);
    axr(TXSC_ADDR, 32'h24, RESP_OKAY);
    repeat (40) @(posedge aclk);
    axw(TXSC_ADDR, 32'h04, RESP_OKAY);
    chk("pin_oe", {31'h0, pin_oe}, 32'h0);
    axr(TXSC_ADDR, 32'h06, RESP_OKAY);
    $display("test abort done");
  endtask : t_abort
  // reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pins();
    t_sync();
    t_frames();
    t_fifo();
    t_abort();
    print_verdict();
  end
endmodule : test_usart_transmit_control
`default_nettype wire
